// *** pkg/link_sync_params.svh ***
// Purpose: register offsets, field positions and reset values
// Assumes: byte addresses on an 8-bit register port
// Notes: included by bare name; definitions only
`ifndef LINK_SYNC_PARAMS_SVH
`define LINK_SYNC_PARAMS_SVH

// register byte addresses
`define LSC_ADDR_LINK_CTRL 8'h50
`define LSC_ADDR_SYNC_CTRL 8'h54
`define LSC_ADDR_STATUS 8'h58
`define LSC_ADDR_CFG_A 8'ha0
`define LSC_ADDR_CFG_B 8'ha4
`define LSC_ADDR_CFG_C 8'ha8
`define LSC_ADDR_CFG_D 8'hac

// link_layer_rx_control fields
`define LSC_SEL_HI 10
`define LSC_SEL_LO 7
`define LSC_LANE_DIS_BIT 2
`define LSC_FRAME_DIS_BIT 1
`define LSC_SYNC_EN_BIT 0

// sync_and_sysref_control fields
`define LSC_EXT_HI 24
`define LSC_EXT_LO 21
`define LSC_BYPASS_BIT 20
`define LSC_OFS_HI 19
`define LSC_OFS_LO 12
`define LSC_SINGLE_BIT 2

// reset values
`define LSC_SEL_RST 4'h0
`define LSC_LANE_DIS_RST 1'b0
`define LSC_FRAME_DIS_RST 1'b0
`define LSC_SYNC_EN_RST 1'b1
`define LSC_EXT_RST 4'h0
`define LSC_BYPASS_RST 1'b0
`define LSC_OFS_RST 8'h00
`define LSC_SINGLE_RST 1'b1

`endif

// *** pkg/link_sync_pkg.sv ***
// Purpose: shared types of the receive link control
// Assumes: nothing
// Notes: constants live in link_sync_params.svh
`default_nettype none
package link_sync_pkg;
	// receive data link state
	typedef enum logic [1:0] {
		st_cgs = 2'b00,
		st_extend = 2'b01,
		st_ilas = 2'b10,
		st_data = 2'b11
	} dll_state_t;
endpackage
`default_nettype wire

// *** pkg/lmfc_if.sv ***
// Purpose: carrier between link control and its lmfc counter
// Assumes: single link clock
// Notes: tick marks the wrap cycle
`timescale 1ns/10ps
`default_nettype none
interface lmfc_if #(parameter int W = 8);
	logic [W-1:0] count;
	logic [W-1:0] load_value;
	logic [W-1:0] max;
	logic load;
	logic tick;
	modport counter(input load, load_value, max, output count, tick);
	modport ctrl(output load, load_value, max, input count, tick);
endinterface
`default_nettype wire

// *** verilog/lmfc_counter.sv ***
// Purpose: local multiframe counter on the link clock
// Assumes: load_value already clipped to 0..max
// Notes: tick is combinational, high while count equals max
`timescale 1ns/10ps
`default_nettype none
module lmfc_counter #(parameter int W = 8) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	lmfc_if.counter lmfc
);
	// load beats wrap so a sysref edge realigns at once
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lmfc.count <= '0;
		end else if (lmfc.load) begin
			lmfc.count <= lmfc.load_value;
		end else if (lmfc.tick) begin
			lmfc.count <= '0;
		end else begin
			lmfc.count <= lmfc.count + W'(1);
		end
	end

	assign lmfc.tick = (lmfc.count == lmfc.max);
endmodule
`default_nettype wire

// *** verilog/pin_sync.sv ***
// Purpose: three-stage synchroniser with rising edge pulse
// Assumes: pin is asynchronous to clock_in
// Notes: a change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic pin_in,
	output logic level_out,
	output logic rise_out
);
	logic stage1;
	logic stage2;
	logic stage3;

	// stage1 feeds only stage2 to keep metastability contained
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			level_out <= 1'b0;
			rise_out <= 1'b0;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				level_out <= stage3;
			end
			rise_out <= (stage2 == stage3) && stage3 && !level_out;
		end
	end
endmodule
`default_nettype wire

// *** verilog/jesd_rx_link_sync_control.sv ***
// Purpose: receive link startup, sync_n and lmfc control
// Assumes: lane status inputs are on clock_in; sysref is a pin
// Notes: subclass, F and K are fixed when the block is built
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "link_sync_params.svh"

module jesd_rx_link_sync_control #(
	parameter int LANES = 8,
	parameter int SUBCLASS = 1,
	parameter int F = 2,
	parameter int K = 32
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic [LANES*128-1:0] cfg_capture_in,
	input wire logic sysref_in,
	input wire logic cgs_done_in,
	input wire logic ilas_done_in,
	input wire logic user_data_in,
	input wire logic link_lost_in,
	input wire logic [LANES-1:0] a_char_in,
	input wire logic [LANES-1:0] f_char_in,
	input wire logic frame_end_in,
	output logic sync_n_out,
	output logic [1:0] dll_state_out,
	output logic checks_active_out,
	output logic lane_check_en_out,
	output logic frame_check_en_out,
	output logic lane_sync_en_out,
	output logic buffer_release_out,
	output logic lane_align_err_out,
	output logic frame_align_err_out,
	output logic [7:0] lmfc_count_out,
	output logic lmfc_tick_out
);
	////////////////////////////////////////////////////////////////////
	// build-time checks and constants

	localparam logic [7:0] LMFC_MAX = 8'(F * K / 4 - 1);

	if (LANES < 1 || LANES > 16 || SUBCLASS < 0 || SUBCLASS > 2 ||
		(F * K) % 4 != 0 || F * K / 4 < 1 || F * K / 4 > 256) begin : g_bad
		$error("link control parameters out of range");
	end

	////////////////////////////////////////////////////////////////////
	// declarations

	link_sync_pkg::dll_state_t state;
	link_sync_pkg::dll_state_t next_state;
	logic [3:0] lane_sel;
	logic lane_dis;
	logic frame_dis;
	logic sync_en;
	logic [3:0] ext_delay;
	logic bypass;
	logic [7:0] lmfc_ofs;
	logic single_req;
	logic sysref_seen;
	logic sysref_rise;
	logic sysref_level;
	logic [3:0] ext_cnt;
	logic [3:0] next_ext_cnt;
	logic released;
	logic exit_ok;
	logic ext_step;
	logic [127:0] sel_words;
	logic wr_link;
	logic wr_sync;
	logic [31:0] next_rdata;
	lmfc_if #(.W(8)) lmfc_bus();

	////////////////////////////////////////////////////////////////////
	// sysref pin and lmfc counter

	pin_sync u_sysref_sync (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.pin_in(sysref_in),
		.level_out(sysref_level),
		.rise_out(sysref_rise)
	);

	lmfc_counter #(.W(8)) u_lmfc (
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.lmfc(lmfc_bus)
	);

	// every detected edge reloads, continuous or single detect
	assign lmfc_bus.load = sysref_rise;
	// an offset past the multiframe would never wrap, so use zero
	assign lmfc_bus.load_value = (lmfc_ofs > LMFC_MAX) ? 8'h00 :
		lmfc_ofs;
	assign lmfc_bus.max = LMFC_MAX;
	assign lmfc_count_out = lmfc_bus.count;
	assign lmfc_tick_out = lmfc_bus.tick;

	////////////////////////////////////////////////////////////////////
	// register writes

	assign wr_link = wr_in && (addr_in == `LSC_ADDR_LINK_CTRL);
	assign wr_sync = wr_in && (addr_in == `LSC_ADDR_SYNC_CTRL);

	// link control; only the documented fields take writes
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lane_sel <= `LSC_SEL_RST;
			lane_dis <= `LSC_LANE_DIS_RST;
			frame_dis <= `LSC_FRAME_DIS_RST;
			sync_en <= `LSC_SYNC_EN_RST;
		end else if (wr_link) begin
			lane_sel <= wdata_in[`LSC_SEL_HI:`LSC_SEL_LO];
			lane_dis <= wdata_in[`LSC_LANE_DIS_BIT];
			frame_dis <= wdata_in[`LSC_FRAME_DIS_BIT];
			sync_en <= wdata_in[`LSC_SYNC_EN_BIT];
		end
	end

	// sync and sysref control fields
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ext_delay <= `LSC_EXT_RST;
			bypass <= `LSC_BYPASS_RST;
			lmfc_ofs <= `LSC_OFS_RST;
		end else if (wr_sync) begin
			ext_delay <= wdata_in[`LSC_EXT_HI:`LSC_EXT_LO];
			// bypass only exists in subclass 1; elsewhere it stays 0
			bypass <= (SUBCLASS == 1) && wdata_in[`LSC_BYPASS_BIT];
			lmfc_ofs <= wdata_in[`LSC_OFS_HI:`LSC_OFS_LO];
		end
	end

	// single detect request: software set wins over hardware clear
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			single_req <= `LSC_SINGLE_RST;
		end else if (wr_sync) begin
			single_req <= wdata_in[`LSC_SINGLE_BIT];
		end else if (single_req && sysref_rise) begin
			single_req <= 1'b0;
		end
	end

	// sampled flag; an edge wins over a rearm in the same cycle
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sysref_seen <= 1'b0;
		end else if (sysref_rise) begin
			sysref_seen <= 1'b1;
		end else if (wr_sync && wdata_in[`LSC_SINGLE_BIT]) begin
			sysref_seen <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// register reads

	// selected lane's four captured words, zero for a missing lane
	always_comb begin
		sel_words = '0;
		if (int'(lane_sel) < LANES) begin
			sel_words = cfg_capture_in[int'(lane_sel)*128 +: 128];
		end
	end

	// read mux; unmapped and reserved bits answer zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (rd_in) begin
			unique case (addr_in)
				`LSC_ADDR_LINK_CTRL: begin
					next_rdata[`LSC_SEL_HI:`LSC_SEL_LO] = lane_sel;
					next_rdata[`LSC_LANE_DIS_BIT] = lane_dis;
					next_rdata[`LSC_FRAME_DIS_BIT] = frame_dis;
					next_rdata[`LSC_SYNC_EN_BIT] = sync_en;
				end
				`LSC_ADDR_SYNC_CTRL: begin
					next_rdata[`LSC_EXT_HI:`LSC_EXT_LO] = ext_delay;
					next_rdata[`LSC_BYPASS_BIT] = bypass;
					next_rdata[`LSC_OFS_HI:`LSC_OFS_LO] = lmfc_ofs;
					next_rdata[`LSC_SINGLE_BIT] = single_req;
				end
				`LSC_ADDR_STATUS: begin
					next_rdata[1:0] = state;
					next_rdata[2] = sync_n_out;
					next_rdata[3] = sysref_seen;
					next_rdata[4] = sysref_level;
				end
				`LSC_ADDR_CFG_A: next_rdata = sel_words[31:0];
				`LSC_ADDR_CFG_B: next_rdata = sel_words[63:32];
				`LSC_ADDR_CFG_C: next_rdata = sel_words[95:64];
				`LSC_ADDR_CFG_D: next_rdata = sel_words[127:96];
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_out <= 32'h0000_0000;
		end else begin
			rdata_out <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// startup state machine

	// subclass 1 leaves cgs on a tick, once sysref is in or bypass is set
	assign exit_ok = cgs_done_in && ((SUBCLASS != 1) ||
		(((sysref_seen && !single_req) || bypass) && lmfc_bus.tick));
	// extension unit: a clock in subclass 0, a multiframe otherwise
	assign ext_step = (SUBCLASS == 0) ? 1'b1 : lmfc_bus.tick;

	always_comb begin
		next_state = state;
		next_ext_cnt = ext_cnt;
		unique case (state)
			link_sync_pkg::st_cgs: begin
				if (exit_ok) begin
					if (ext_delay == 4'h0) begin
						next_state = sync_en ? link_sync_pkg::st_ilas :
							link_sync_pkg::st_data;
					end else begin
						next_state = link_sync_pkg::st_extend;
						next_ext_cnt = ext_delay;
					end
				end
			end
			link_sync_pkg::st_extend: begin
				if (ext_step) begin
					next_ext_cnt = ext_cnt - 4'h1;
					if (ext_cnt == 4'h1) begin
						next_state = sync_en ? link_sync_pkg::st_ilas :
							link_sync_pkg::st_data;
					end
				end
			end
			link_sync_pkg::st_ilas: begin
				if (ilas_done_in) begin
					next_state = link_sync_pkg::st_data;
				end
			end
			link_sync_pkg::st_data: begin
				next_state = link_sync_pkg::st_data;
			end
		endcase
		// losing the link restarts from code group sync
		if (link_lost_in) begin
			next_state = link_sync_pkg::st_cgs;
			next_ext_cnt = 4'h0;
		end
	end

	// state, extension count and sync_n move together
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= link_sync_pkg::st_cgs;
			ext_cnt <= 4'h0;
			sync_n_out <= 1'b0;
		end else begin
			state <= next_state;
			ext_cnt <= next_ext_cnt;
			sync_n_out <= (next_state == link_sync_pkg::st_ilas) ||
				(next_state == link_sync_pkg::st_data);
		end
	end

	assign dll_state_out = state;

	////////////////////////////////////////////////////////////////////
	// buffer release and alignment checks

	// one release per startup: end of ilas, or first user data when sync_en is off
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			buffer_release_out <= 1'b0;
			released <= 1'b0;
		end else begin
			// a steady user_data_in would otherwise give a double pulse
			buffer_release_out <= !released && !buffer_release_out &&
				!link_lost_in && (
				(sync_en && state == link_sync_pkg::st_ilas && ilas_done_in) ||
				(!sync_en && state == link_sync_pkg::st_data &&
				user_data_in));
			if (link_lost_in || state == link_sync_pkg::st_cgs) begin
				released <= 1'b0;
			end else if (buffer_release_out) begin
				released <= 1'b1;
			end
		end
	end

	// checks start at ilas, or at data when ilas is skipped
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			checks_active_out <= 1'b0;
		end else begin
			checks_active_out <= (next_state == link_sync_pkg::st_data) ||
				(sync_en && next_state == link_sync_pkg::st_ilas);
		end
	end

	assign lane_check_en_out = !lane_dis;
	assign frame_check_en_out = !frame_dis;
	assign lane_sync_en_out = sync_en;

	// /A/ must land on all lanes together; /F/ only at frame end
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lane_align_err_out <= 1'b0;
			frame_align_err_out <= 1'b0;
		end else begin
			lane_align_err_out <= checks_active_out && !lane_dis &&
				(|a_char_in) && !(&a_char_in);
			frame_align_err_out <= checks_active_out && !frame_dis &&
				(|(f_char_in & ~{LANES{frame_end_in}}));
		end
	end

	////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);

	cfg_select_a: assert property (
		rd_in && addr_in == `LSC_ADDR_CFG_A && int'(lane_sel) < LANES
		|=> rdata_out == $past(cfg_capture_in[int'(lane_sel)*128 +: 32]))
		else $error("wrong lane words on readback");

	cfg_zero_a: assert property (
		rd_in && addr_in == `LSC_ADDR_CFG_D && int'(lane_sel) >= LANES
		|=> rdata_out == 32'h0000_0000)
		else $error("missing lane not read as zero");

	lane_check_a: assert property (
		lane_align_err_out |-> !$past(lane_dis) && $past(|a_char_in))
		else $error("lane alignment error while disabled");

	frame_check_a: assert property (
		frame_align_err_out |-> !$past(frame_dis) && !$past(frame_end_in))
		else $error("frame alignment error while disabled");

	ilas_entry_a: assert property (
		state == link_sync_pkg::st_ilas && $past(state) != state
		|-> $past(sync_en))
		else $error("ilas entered with lane sync off");

	skip_ilas_a: assert property (
		state == link_sync_pkg::st_data &&
		($past(state) == link_sync_pkg::st_cgs ||
		$past(state) == link_sync_pkg::st_extend) |-> !$past(sync_en))
		else $error("ilas skipped with lane sync on");

	cgs_exit_a: assert property (
		$past(state) == link_sync_pkg::st_cgs && state !=
		link_sync_pkg::st_cgs && SUBCLASS == 1
		|-> $past(lmfc_bus.tick) && ($past(bypass) || $past(sysref_seen)))
		else $error("cgs left without sysref or off tick");

	sync_low_a: assert property (
		state == link_sync_pkg::st_extend |=> !sync_n_out ||
		$past(ext_cnt) == 4'h1 || $past(link_lost_in))
		else $error("sync_n released during extension");

	lmfc_load_a: assert property (
		sysref_rise |=> lmfc_bus.count == $past(lmfc_bus.load_value))
		else $error("lmfc not loaded on sysref edge");

	lmfc_range_a: assert property (
		lmfc_bus.count <= LMFC_MAX)
		else $error("lmfc counter out of range");

	single_clear_a: assert property (
		single_req && sysref_rise && !wr_sync |=> !single_req ##1
		sysref_seen || sysref_rise)
		else $error("single detect request not cleared");

	lmfc_wrap_a: assert property (
		lmfc_bus.tick && !sysref_rise |=> lmfc_bus.count == 8'h00)
		else $error("lmfc did not wrap");

	release_pulse_a: assert property (
		buffer_release_out |=> !buffer_release_out)
		else $error("buffer release longer than one cycle");

	startup_c: cover property (
		state == link_sync_pkg::st_ilas ##[1:200]
		state == link_sync_pkg::st_data);
	bypass_c: cover property (
		!sync_en && buffer_release_out);
	extend_c: cover property (
		state == link_sync_pkg::st_extend ##1 sync_n_out);
endmodule
`default_nettype wire

// *** tb/converter_tx_model.sv ***
// Purpose: far-side transmitter model driving lane status into the block
// Assumes: one link clock; frame end every other cycle, multiframe 16
// Notes: bad_a/bad_f inputs break alignment on command only
`timescale 1ns/10ps
`default_nettype none
module converter_tx_model #(
	parameter int ILAS_LEN = 20
) (
	input wire logic clock_in,
	input wire logic rst_b_in,
	input wire logic sync_n_in,
	input wire logic lane_sync_en_in,
	input wire logic bad_a_in,
	input wire logic bad_f_in,
	output logic cgs_done_out,
	output logic ilas_done_out,
	output logic user_data_out,
	output logic [7:0] a_char_out,
	output logic [7:0] f_char_out,
	output logic frame_end_out
);
	logic [7:0] cnt;
	logic in_ilas;
	logic sync_q;

	////////////////////////////////////////////////////////////////////////
	// cgs while sync_n low, restart count on each new request
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt <= 8'h00;
			sync_q <= 1'b0;
			in_ilas <= 1'b0;
			cgs_done_out <= 1'b0;
			ilas_done_out <= 1'b0;
			user_data_out <= 1'b0;
		end else if (!sync_n_in) begin
			sync_q <= 1'b0;
			cnt <= sync_q ? 8'h00 : ((cnt < 8'h08) ? cnt + 8'h01 : cnt);
			cgs_done_out <= !sync_q && (cnt >= 8'h07);
			in_ilas <= lane_sync_en_in;
			ilas_done_out <= 1'b0;
			user_data_out <= 1'b0;
		end else begin
			sync_q <= 1'b1;
			cnt <= cnt + 8'h01;
			ilas_done_out <= in_ilas && (cnt == 8'(8 + ILAS_LEN));
			// no ilas when sync disabled: straight to user data
			if (!in_ilas || cnt == 8'(8 + ILAS_LEN)) begin
				in_ilas <= 1'b0;
				user_data_out <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control characters only in user data, lane 0 alone when bad_a
	assign frame_end_out = cnt[0];
	assign f_char_out = (user_data_out && (cnt[0] || bad_f_in)) ?
		8'hff : 8'h00;
	assign a_char_out = (user_data_out && cnt[3:0] == 4'hf) ?
		(bad_a_in ? 8'h01 : 8'hff) : 8'h00;
endmodule
`default_nettype wire

// *** tb/jesd_rx_link_sync_control_test.sv ***
// Purpose: self-checking bench for receive link sync control
// Assumes: default build, subclass 1, multiframe of 16 link clocks
// Notes: inputs driven by nonblocking assignment after rising edges
`timescale 1ns/10ps
`default_nettype none
`include "link_sync_params.svh"
module jesd_rx_link_sync_control_test;
	logic clock_in, rst_b_in, wr_in, rd_in, sysref_in, link_lost_in;
	logic [7:0] addr_in, a_char, f_char, lmfc_count_out;
	logic [31:0] wdata_in, rdata_out;
	logic [1023:0] cfg_capture_in;
	logic cgs_done, ilas_done, user_data, frame_end, sync_n_out;
	logic [1:0] dll_state_out;
	logic checks_active_out, lane_check_en_out, frame_check_en_out;
	logic lane_sync_en_out, buffer_release_out, lane_err, frame_err;
	logic lmfc_tick_out, bad_a, bad_f;
	int n_fail = 0;
	int n_tests = 0;

	jesd_rx_link_sync_control u_dut (.clock_in(clock_in),
		.rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.cfg_capture_in(cfg_capture_in), .sysref_in(sysref_in),
		.cgs_done_in(cgs_done), .ilas_done_in(ilas_done),
		.user_data_in(user_data), .link_lost_in(link_lost_in),
		.a_char_in(a_char), .f_char_in(f_char), .frame_end_in(frame_end),
		.sync_n_out(sync_n_out), .dll_state_out(dll_state_out),
		.checks_active_out(checks_active_out),
		.lane_check_en_out(lane_check_en_out),
		.frame_check_en_out(frame_check_en_out),
		.lane_sync_en_out(lane_sync_en_out),
		.buffer_release_out(buffer_release_out),
		.lane_align_err_out(lane_err), .frame_align_err_out(frame_err),
		.lmfc_count_out(lmfc_count_out), .lmfc_tick_out(lmfc_tick_out));
	converter_tx_model u_tx (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.sync_n_in(sync_n_out), .lane_sync_en_in(lane_sync_en_out),
		.bad_a_in(bad_a), .bad_f_in(bad_f), .cgs_done_out(cgs_done),
		.ilas_done_out(ilas_done), .user_data_out(user_data),
		.a_char_out(a_char), .f_char_out(f_char),
		.frame_end_out(frame_end));

	////////////////////////////////////////////////////////////////////////
	// shared helpers for bus cycles and comparisons
	function automatic logic [31:0] cfgw(input int l, input int w);
		return {8'ha5, 4'(l), 4'(w), 16'h3c3c};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clock_in);
		rd_in <= 1'b0;
		@(negedge clock_in);
		chk(rdata_out, e);
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		rchk(`LSC_ADDR_LINK_CTRL, 32'h0000_0001);
		rchk(`LSC_ADDR_SYNC_CTRL, 32'h0000_0004);
		rchk(8'h5c, 32'h0);
		chk(lane_check_en_out, 32'h1);
		chk(frame_check_en_out, 32'h1);
		$display("test reset values done");
	endtask
	task automatic t_startup();
		logic prev_tick = 1'b0;
		logic seen_ilas = 1'b0;
		logic seen_rel = 1'b0;
		repeat (40) @(negedge clock_in);
		chk(dll_state_out, 32'h0);
		chk(sync_n_out, 32'h0);
		@(posedge clock_in);
		sysref_in <= 1'b1;
		for (int i = 0; i < 120 && dll_state_out !== 2'd3; i++) begin
			@(posedge clock_in);
			if (i == 8) sysref_in <= 1'b0;
			@(negedge clock_in);
			if (dll_state_out === 2'd2 && !seen_ilas) chk(prev_tick, 1);
			if (dll_state_out === 2'd2) chk(checks_active_out, 1);
			seen_ilas |= (dll_state_out === 2'd2);
			seen_rel |= buffer_release_out;
			prev_tick = lmfc_tick_out;
		end
		chk(seen_ilas, 32'h1);
		chk(dll_state_out, 32'h3);
		chk(seen_rel, 32'h1);
		chk(sync_n_out, 32'h1);
		rchk(`LSC_ADDR_SYNC_CTRL, 32'h0);
		$display("test startup done");
	endtask
	task automatic t_regs();
		wr(`LSC_ADDR_LINK_CTRL, 32'hffff_ffff);
		rchk(`LSC_ADDR_LINK_CTRL, 32'h0000_0787);
		chk(lane_check_en_out, 32'h0);
		chk(frame_check_en_out, 32'h0);
		wr(`LSC_ADDR_SYNC_CTRL, 32'hffff_ffff);
		rchk(`LSC_ADDR_SYNC_CTRL, 32'h01ff_f004);
		wr(`LSC_ADDR_LINK_CTRL, 32'h1);
		wr(`LSC_ADDR_SYNC_CTRL, 32'h0);
		$display("test register access done");
	endtask
	task automatic t_lmfc(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] prev;
		int jumps = 0;
		wr(`LSC_ADDR_SYNC_CTRL, {12'h0, ofs, 12'h0});
		// start from a wrap so the load cannot pass for a plain step
		@(negedge clock_in);
		for (int i = 0; i < 20 && lmfc_count_out !== 8'd15; i++)
			@(negedge clock_in);
		prev = lmfc_count_out;
		for (int i = 0; i < 24; i++) begin
			@(posedge clock_in);
			sysref_in <= (i < 9);
			@(negedge clock_in);
			chk(lmfc_tick_out, lmfc_count_out == 8'd15);
			// a step other than plus one mod 16 is the load
			if (lmfc_count_out !== ((prev + 8'h01) & 8'h0f)) begin
				jumps++;
				chk(lmfc_count_out, exp);
			end
			prev = lmfc_count_out;
		end
		chk(jumps, 32'h1);
		$display("test lmfc offset %0d done", ofs);
	endtask
	task automatic t_align();
		int errs;
		for (int k = 0; k < 4; k++) begin
			wr(`LSC_ADDR_LINK_CTRL, 32'h1 | (k == 1 ? 32'h4 : 32'h0) |
				(k == 3 ? 32'h2 : 32'h0));
			bad_a <= (k < 2);
			bad_f <= (k >= 2);
			errs = 0;
			// enables follow the write only once its edge has settled
			@(negedge clock_in);
			chk(lane_check_en_out, 32'(k != 1));
			chk(frame_check_en_out, 32'(k != 3));
			repeat (40) begin
				@(negedge clock_in);
				errs += (k < 2) ? int'(lane_err) : int'(frame_err);
			end
			chk(errs > 0, 32'(k % 2 == 0));
			@(posedge clock_in);
			bad_a <= 1'b0;
			bad_f <= 1'b0;
		end
		wr(`LSC_ADDR_LINK_CTRL, 32'h1);
		$display("test alignment checks done");
	endtask
	task automatic t_select();
		for (int s = 0; s < 16; s++) begin
			wr(`LSC_ADDR_LINK_CTRL, 32'(s << 7) | 32'h1);
			for (int w = 0; w < 4; w++)
				rchk(8'(`LSC_ADDR_CFG_A + 4 * w), s < 8 ? cfgw(s, w) : 32'h0);
		end
		$display("test lane select done");
	endtask
	task automatic t_extend();
		int n_ext = 0;
		logic seen_ilas = 1'b0;
		logic seen_rel = 1'b0;
		wr(`LSC_ADDR_LINK_CTRL, 32'h0);
		// rearm single detect so only the bypass can open cgs
		wr(`LSC_ADDR_SYNC_CTRL, 32'h0050_0004);
		@(posedge clock_in);
		link_lost_in <= 1'b1;
		@(posedge clock_in);
		link_lost_in <= 1'b0;
		for (int i = 0; i < 320; i++) begin
			@(negedge clock_in);
			if (dll_state_out === 2'd1) chk(sync_n_out, 0);
			n_ext += int'(dll_state_out === 2'd1);
			seen_ilas |= (dll_state_out === 2'd2);
			seen_rel |= buffer_release_out;
		end
		chk(n_ext, 32'd32);
		chk(seen_ilas, 32'h0);
		chk(dll_state_out, 32'h3);
		chk(seen_rel, 32'h1);
		$display("test sync disabled with extension done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// verdict, clock, watchdog and main sequence
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end
	initial begin
		#400000;
		n_fail++;
		end_of_test();
	end
	initial begin
		rst_b_in = 1'b0;
		{wr_in, rd_in, sysref_in, link_lost_in, bad_a, bad_f} = 6'h00;
		addr_in = 8'h00;
		wdata_in = 32'h0;
		for (int l = 0; l < 8; l++)
			for (int w = 0; w < 4; w++)
				cfg_capture_in[(l * 4 + w) * 32 +: 32] = cfgw(l, w);
		repeat (3) @(posedge clock_in);
		rst_b_in <= 1'b1;
		t_reset();
		t_startup();
		t_regs();
		t_lmfc(8'd11, 8'd11);
		t_lmfc(8'd15, 8'd15);
		t_lmfc(8'd16, 8'd0);
		t_align();
		t_select();
		t_extend();
		end_of_test();
	end
endmodule
`default_nettype wire
